// ==== common/cdr_dec_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface cdr_dec_if;
  import cdr_pkg::*;
  logic [CDR_ADDR_W-1:0] addr;
  logic hit;
  logic [CDR_IDX_W-1:0] idx;
  modport dec (input addr, output hit, output idx);
  modport req (output addr, input hit, input idx);
endinterface : cdr_dec_if
`default_nettype wire

// ==== common/cdr_pkg.sv ====
// Notes on behaviour
// - Partition id width register returns the width in bits [3:0]; upper bits reserved.
// - Buffer depth register at 0x08E64 is read-only and returns the configured depth.
// - Prefetch register at 0x08E68 is read-only; bit 0 shows prefetch support.
// - Data RAM kind register at 0x08E6C is read-only; kind code in bits [1:0].
// - RAM kind fields hold the configured kind directly as a binary number.
// - Slot RAM kind register at 0x08E70 is read-only; kind code in bits [1:0].
// - Cache RAM kind register at 0x08E74 is read-only; kind code in bits [1:0].
// - Walk data width register at 0x08E78 is read-only; width in bits [9:0].
// - Every register is 32 bits, always present, reset and read value equal parameter.
// - Partition id width register sits at offset 0x08E60 and is read-only.
package cdr_pkg;

  localparam int CDR_ADDR_W = 16;
  localparam int CDR_DATA_W = 32;
  localparam int CDR_NUM_REGS = 7;
  localparam int CDR_IDX_W = 3;

  // Byte offsets of the discovery registers.
  localparam logic [15:0] CDR_OFF_PART_W = 16'h8E60;
  localparam logic [15:0] CDR_OFF_DEPTH = 16'h8E64;
  localparam logic [15:0] CDR_OFF_PREF = 16'h8E68;
  localparam logic [15:0] CDR_OFF_DATA_RAM = 16'h8E6C;
  localparam logic [15:0] CDR_OFF_SLOT_RAM = 16'h8E70;
  localparam logic [15:0] CDR_OFF_CACHE_RAM = 16'h8E74;
  localparam logic [15:0] CDR_OFF_WALK_W = 16'h8E78;

  // Register indices, in the order of the offset table below.
  localparam int CDR_IDX_PART_W = 0;
  localparam int CDR_IDX_DEPTH = 1;
  localparam int CDR_IDX_PREF = 2;
  localparam int CDR_IDX_DATA_RAM = 3;
  localparam int CDR_IDX_SLOT_RAM = 4;
  localparam int CDR_IDX_CACHE_RAM = 5;
  localparam int CDR_IDX_WALK_W = 6;

  localparam logic [CDR_NUM_REGS-1:0][15:0] CDR_OFFSETS = {
    CDR_OFF_WALK_W, CDR_OFF_CACHE_RAM, CDR_OFF_SLOT_RAM, CDR_OFF_DATA_RAM,
    CDR_OFF_PREF, CDR_OFF_DEPTH, CDR_OFF_PART_W
  };

  // Field widths; every field starts at bit 0.
  localparam int CDR_FIELD_LSB = 0;
  localparam int CDR_PART_W_WID = 4;
  localparam int CDR_DEPTH_WID = 7;
  localparam int CDR_PREF_WID = 1;
  localparam int CDR_RAM_WID = 2;
  localparam int CDR_WALK_W_WID = 10;

  // Default build-time values, reported as the reset values.
  localparam logic [3:0] CDR_PART_W_RST = 4'h9;
  localparam logic [6:0] CDR_DEPTH_RST = 7'h40;
  localparam logic [0:0] CDR_PREF_RST = 1'h1;
  localparam logic [1:0] CDR_DATA_RAM_RST = 2'h2;
  localparam logic [1:0] CDR_SLOT_RAM_RST = 2'h0;
  localparam logic [1:0] CDR_CACHE_RAM_RST = 2'h1;
  localparam logic [9:0] CDR_WALK_W_RST = 10'h200;

endpackage : cdr_pkg

// ==== rtl/cdr_addr_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module cdr_addr_decode
  import cdr_pkg::*;
(
  cdr_dec_if.dec dec // Byte address in, hit and register index out.
);

  logic [CDR_NUM_REGS-1:0] match;

  // offset map
  // The two low address bits are ignored; a whole word is decoded.
  genvar g;
  for (g = 0; g < CDR_NUM_REGS; g++) begin : g_match
    assign match[g] = (dec.addr[CDR_ADDR_W-1:2] ==
                       CDR_OFFSETS[g][CDR_ADDR_W-1:2]);
  end

  always_comb begin
    dec.idx = '0;
    for (int i = 0; i < CDR_NUM_REGS; i++) begin
      if (match[i]) begin
        dec.idx = CDR_IDX_W'(i);
      end
    end
  end

  assign dec.hit = |match;

endmodule : cdr_addr_decode
`default_nettype wire

// ==== rtl/cdr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module cdr_top
  import cdr_pkg::*;
#(
  parameter logic [3:0] partition_id_width_param = CDR_PART_W_RST,
  parameter logic [6:0] buffer_depth_param = CDR_DEPTH_RST,
  parameter logic [0:0] prefetch_present_param = CDR_PREF_RST,
  parameter logic [1:0] data_ram_kind_param = CDR_DATA_RAM_RST,
  parameter logic [1:0] slot_ram_kind_param = CDR_SLOT_RAM_RST,
  parameter logic [1:0] cache_ram_kind_param = CDR_CACHE_RAM_RST,
  parameter logic [9:0] walk_data_width_param = CDR_WALK_W_RST
) (
  input wire logic pclk, // APB clock, 10 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // Slave select.
  input wire logic penable, // Access phase marker.
  input wire logic pwrite, // High for a write transfer.
  input wire logic [CDR_ADDR_W-1:0] paddr, // Byte address.
  input wire logic [CDR_DATA_W-1:0] pwdata, // Write data, discarded.
  output logic [CDR_DATA_W-1:0] prdata, // Read data.
  output logic pready, // Transfer complete.
  output logic pslverr // Unmapped address.
);

  typedef struct packed {
    logic [CDR_NUM_REGS-1:0][CDR_DATA_W-1:0] regs;
    logic [CDR_DATA_W-1:0] rdata;
    logic ready;
    logic err;
  } cdr_state_t;

  // reset values
  // Each field is zero-extended so that the reserved bits hold zero.
  localparam logic [CDR_NUM_REGS-1:0][CDR_DATA_W-1:0] RST_REGS = {
    32'(walk_data_width_param),
    32'(cache_ram_kind_param),
    32'(slot_ram_kind_param),
    32'(data_ram_kind_param),
    32'(prefetch_present_param),
    32'(buffer_depth_param),
    32'(partition_id_width_param)
  };

  localparam cdr_state_t ST_RST = '{
    regs: RST_REGS,
    rdata: '0,
    ready: 1'b0,
    err: 1'b0
  };

  cdr_state_t st_q;
  cdr_state_t st_d;

  cdr_dec_if dec_if ();

  assign dec_if.addr = paddr;

  cdr_addr_decode u_decode (
    .dec (dec_if.dec)
  );

  logic setup;
  logic done;

  assign setup = psel && !penable;
  assign done = psel && penable && st_q.ready;

  always_comb begin
    st_d = st_q;
    // writes ignored
    // The register array is never loaded from pwdata, so a write can
    // only complete the transfer and cannot disturb any value.
    st_d.regs = st_q.regs;
    if (done) begin
      st_d.ready = 1'b0;
      st_d.err = 1'b0;
      st_d.rdata = '0;
    end else if (setup) begin
      // Answering from the setup cycle gives zero wait states while the
      // outputs still come straight from flip-flops.
      st_d.ready = 1'b1;
      st_d.err = !dec_if.hit;
      if (!pwrite && dec_if.hit) begin
        st_d.rdata = st_q.regs[dec_if.idx];
      end else begin
        st_d.rdata = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.err;

  // Checks on the bus handshake, the idle outputs, the read-back values and the fixed register array.
  default clocking cb @(posedge pclk);
  endclocking

  default disable iff (!presetn);

  logic rd_done;
  logic wr_done;

  assign rd_done = psel && penable && pready && !pwrite;
  assign wr_done = psel && penable && pready && pwrite;

  chk_zero_wait_answer: assert property (
    psel && !penable |=> pready && psel && penable
      || !psel || !penable
  ) else $error("pready did not follow the setup cycle");

  chk_setup_gives_ready: assert property (
    psel && !penable ##1 psel && penable |-> pready
  ) else $error("access phase started without pready");

  chk_ready_single: assert property (
    psel && penable && pready |=> !pready
  ) else $error("pready held past the completing edge");

  chk_part_width_read: assert property (
    rd_done && paddr[15:2] == CDR_OFF_PART_W[15:2] |->
      prdata[3:0] == partition_id_width_param && prdata[31:4] == 28'h0
  ) else $error("partition id width read back wrong");

  chk_part_width_offset: assert property (
    psel && penable && pready &&
      paddr[15:2] == CDR_OFF_PART_W[15:2] |-> !pslverr
  ) else $error("partition id width offset not mapped");

  chk_depth_read: assert property (
    rd_done && paddr[15:2] == CDR_OFF_DEPTH[15:2] |->
      prdata == 32'(buffer_depth_param) && !pslverr
  ) else $error("buffer depth read back wrong");

  chk_prefetch_read: assert property (
    rd_done && paddr[15:2] == CDR_OFF_PREF[15:2] |->
      prdata[0] == prefetch_present_param && prdata[31:1] == 31'h0
  ) else $error("prefetch support read back wrong");

  chk_data_ram_read: assert property (
    rd_done && paddr[15:2] == CDR_OFF_DATA_RAM[15:2] |->
      prdata[1:0] == data_ram_kind_param && prdata[31:2] == 30'h0
  ) else $error("data RAM kind read back wrong");

  chk_ram_kind_binary: assert property (
    rd_done && (paddr[15:2] == CDR_OFF_DATA_RAM[15:2] ||
      paddr[15:2] == CDR_OFF_SLOT_RAM[15:2] ||
      paddr[15:2] == CDR_OFF_CACHE_RAM[15:2]) |->
      prdata < 32'h00000004
  ) else $error("RAM kind field not a plain two-bit value");

  chk_slot_ram_read: assert property (
    rd_done && paddr[15:2] == CDR_OFF_SLOT_RAM[15:2] |->
      prdata == 32'(slot_ram_kind_param) && !pslverr
  ) else $error("slot RAM kind read back wrong");

  chk_cache_ram_read: assert property (
    rd_done && paddr[15:2] == CDR_OFF_CACHE_RAM[15:2] |->
      prdata == 32'(cache_ram_kind_param) && !pslverr
  ) else $error("cache RAM kind read back wrong");

  chk_walk_width_read: assert property (
    rd_done && paddr[15:2] == CDR_OFF_WALK_W[15:2] |->
      prdata[9:0] == walk_data_width_param && prdata[31:10] == 22'h0
  ) else $error("walk data width read back wrong");

  chk_values_fixed: assert property (
    st_q.regs == RST_REGS
  ) else $error("discovery value differs from its parameter");

  chk_write_no_effect: assert property (
    wr_done && dec_if.hit |-> !pslverr && prdata == 32'h0
      ##1 st_q.regs == $past(st_q.regs)
  ) else $error("write to a discovery register had an effect");

  chk_unmapped_error: assert property (
    psel && penable && pready && !dec_if.hit |->
      pslverr && prdata == 32'h0
  ) else $error("unmapped access not answered with an error");

  // Outside a completing cycle the bus must show nothing, so that a
  // master that samples late cannot pick up a stale value.
  chk_idle_rdata_zero: assert property (
    !pready |-> prdata == 32'h0
  ) else $error("read data shown outside a completing cycle");

  chk_idle_err_zero: assert property (
    !pready |-> !pslverr
  ) else $error("error shown outside a completing cycle");

  chk_ready_in_access: assert property (
    pready |-> psel && penable
  ) else $error("pready raised outside an access phase");

  chk_ready_after_setup: assert property (
    pready |-> $past(psel && !penable)
  ) else $error("pready raised without a setup cycle before it");

  chk_mapped_no_error: assert property (
    psel && penable && pready && dec_if.hit |-> !pslverr
  ) else $error("mapped access answered with an error");

  chk_write_zero_data: assert property (
    wr_done |-> prdata == 32'h0
  ) else $error("write returned nonzero read data");

  chk_depth_reserved: assert property (
    rd_done && paddr[15:2] == CDR_OFF_DEPTH[15:2] |->
      prdata[31:7] == 25'h0
  ) else $error("buffer depth reserved bits not zero");

  chk_slot_reserved: assert property (
    rd_done && paddr[15:2] == CDR_OFF_SLOT_RAM[15:2] |->
      prdata[31:2] == 30'h0
  ) else $error("slot RAM kind reserved bits not zero");

  chk_cache_reserved: assert property (
    rd_done && paddr[15:2] == CDR_OFF_CACHE_RAM[15:2] |->
      prdata[31:2] == 30'h0
  ) else $error("cache RAM kind reserved bits not zero");

  chk_part_width_word: assert property (
    rd_done && paddr[15:2] == CDR_OFF_PART_W[15:2] |->
      prdata == 32'(partition_id_width_param) && !pslverr
  ) else $error("partition id width word wrong");

  chk_prefetch_word: assert property (
    rd_done && paddr[15:2] == CDR_OFF_PREF[15:2] |->
      prdata == 32'(prefetch_present_param) && !pslverr
  ) else $error("prefetch support word wrong");

  chk_data_ram_word: assert property (
    rd_done && paddr[15:2] == CDR_OFF_DATA_RAM[15:2] |->
      prdata == 32'(data_ram_kind_param) && !pslverr
  ) else $error("data RAM kind word wrong");

  chk_walk_width_word: assert property (
    rd_done && paddr[15:2] == CDR_OFF_WALK_W[15:2] |->
      prdata == 32'(walk_data_width_param) && !pslverr
  ) else $error("walk data width word wrong");

  // A byte address inside a word must not change what is returned.
  chk_low_bits_ignored: assert property (
    rd_done && paddr[15:2] == CDR_OFF_WALK_W[15:2] && paddr[1:0] != 2'h0
      |-> prdata == 32'(walk_data_width_param)
  ) else $error("low address bits changed the read data");

  chk_rdata_clears: assert property (
    pready |=> prdata == 32'h0
  ) else $error("read data held past the completing edge");

  chk_err_clears: assert property (
    pready |=> !pslverr
  ) else $error("error held past the completing edge");

  chk_offset_mapped: assert property (
    psel && penable && paddr[15:2] == CDR_OFF_PART_W[15:2] |-> dec_if.hit
  ) else $error("partition id width offset not decoded");

  cov_read_part_width: cover property (
    rd_done && paddr[15:2] == CDR_OFF_PART_W[15:2]
  );

  cov_read_walk_width: cover property (
    rd_done && paddr[15:2] == CDR_OFF_WALK_W[15:2]
  );

  cov_write_mapped: cover property (
    wr_done && dec_if.hit
  );

  cov_unmapped: cover property (
    psel && penable && pready && pslverr
  );

  cov_back_to_back: cover property (
    psel && penable && pready ##1 psel && !penable ##1 psel && pready
  );

endmodule : cdr_top
`default_nettype wire

// ==== verif/cdr_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
  total_checks++; \
  if ((got) !== (ex)) begin \
    fails++; \
    $display("BAD %s expected %h seen %h", nm, ex, got); \
  end \
end
module cdr_top_tb
  import cdr_pkg::*;
;
  // Values differ from the package defaults so a hardwired default shows up.
  localparam logic [3:0] PW = 4'h1;
  localparam logic [6:0] DEP = 7'h02;
  localparam logic [0:0] PF = 1'h0;
  localparam logic [1:0] DR = 2'h1;
  localparam logic [1:0] SR = 2'h2;
  localparam logic [1:0] CR = 2'h3;
  localparam logic [9:0] WW = 10'h040;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [CDR_ADDR_W-1:0] paddr;
  logic [CDR_DATA_W-1:0] pwdata, prdata, rdata_seen;
  logic err_seen;
  logic [CDR_DATA_W-1:0] exp_tab [CDR_NUM_REGS];
  logic [CDR_ADDR_W-1:0] bad_tab [4];
  int fails = 0;
  int total_checks = 0;

  always #50 pclk = ~pclk;

  cdr_top #(
    .partition_id_width_param(PW), .buffer_depth_param(DEP),
    .prefetch_present_param(PF), .data_ram_kind_param(DR),
    .slot_ram_kind_param(SR), .cache_ram_kind_param(CR),
    .walk_data_width_param(WW)
  ) u_cdr_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr)
  );

  // With keep set psel stays up so the next setup follows at once.
  task automatic xfer(input logic wr, input logic [15:0] a,
                      input logic [31:0] d, input bit keep);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    if (n == 16) fails++;
    rdata_seen = prdata;
    err_seen = pslverr;
    if (!keep) begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : xfer

  task automatic rd_chk(input string nm, input logic [15:0] a,
                        input logic [31:0] ex, input logic er, input bit keep);
    xfer(1'b0, a, 32'h0, keep);
    `CHK(nm, ex, rdata_seen)
    `CHK(nm, er, err_seen)
  endtask : rd_chk

  task automatic wr_chk(input logic [15:0] a, input logic er);
    xfer(1'b1, a, 32'hFFFFFFFF, 1'b0);
    `CHK("write_data", 32'h0, rdata_seen)
    `CHK("write_err", er, err_seen)
  endtask : wr_chk

  task automatic quiet_chk();
    `CHK("prdata_quiet", 32'h0, prdata)
    `CHK("pready_quiet", 1'b0, pready)
    `CHK("pslverr_quiet", 1'b0, pslverr)
  endtask : quiet_chk

  task automatic summarize();
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (3000) @(posedge pclk);
    fails++;
    summarize();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    exp_tab = '{{28'h0, PW}, {25'h0, DEP}, {31'h0, PF}, {30'h0, DR},
                {30'h0, SR}, {30'h0, CR}, {22'h0, WW}};
    bad_tab = '{16'h8E5C, 16'h8E7C, 16'h0000, 16'h0E60};
    repeat (3) @(posedge pclk);
    quiet_chk();
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < CDR_NUM_REGS; i++) begin
      rd_chk("reg_read", CDR_OFFSETS[i], exp_tab[i], 1'b0, i < 6);
    end
    for (int i = 0; i < CDR_NUM_REGS; i++) begin
      wr_chk(CDR_OFFSETS[i], 1'b0);
      rd_chk("after_write", CDR_OFFSETS[i], exp_tab[i], 1'b0, 1'b0);
    end
    // Low address bits do not select a byte lane.
    rd_chk("low_bits", CDR_OFF_WALK_W | 16'h0003, exp_tab[6], 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rd_chk("unmapped", bad_tab[i], 32'h0, 1'b1, 1'b0);
      wr_chk(bad_tab[i], 1'b1);
    end
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    quiet_chk();
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk("post_reset", CDR_OFF_DEPTH, exp_tab[1], 1'b0, 1'b0);
    summarize();
  end
endmodule : cdr_top_tb
`undef CHK
`default_nettype wire
